// File: shared/cmd_gate_consts.svh
// Constants for the command acceptance and power state gate.
`ifndef CMD_GATE_CONSTS_SVH
`define CMD_GATE_CONSTS_SVH

`define CG_ORD_W 8
`define CG_SYNC_DEPTH 3

`define CG_ORD_SAVE_STATE 8'h00
`define CG_ORD_STARTUP 8'h01
`define CG_ORD_PHYS_PRESENCE 8'h02
`define CG_ORD_ESTAB_RESET 8'h03

`define CG_ORD_ALTER_LO 8'h04
`define CG_ORD_ALTER_HI 8'h1F
`define CG_ORD_MAND_LO 8'h20
`define CG_ORD_MAND_HI 8'h7F
`define CG_ORD_O1_LO 8'h80
`define CG_ORD_O1_HI 8'h84
`define CG_ORD_O2_LO 8'h88
`define CG_ORD_O2_HI 8'h8A
`define CG_ORD_O3_LO 8'h90
`define CG_ORD_O3_HI 8'h91
`define CG_ORD_OPT_LO 8'h98
`define CG_ORD_OPT_HI 8'h9E
`define CG_ORD_DEL_LO 8'hA0
`define CG_ORD_DEL_HI 8'hA4

`define CG_OPT_COUNT 7
`define CG_DSTATE_D3 2'h3

`define CG_RST_SAVED_VALID 1'b0
`define CG_RST_SYNC 3'h0
`define CG_RST_INIT_FILT 1'b0
`define CG_RST_PD_FILT 1'b1

`endif

// File: shared/cmd_gate_pkg.sv
// Types shared by the command gate and its ordinal attribute table.
package cmd_gate_pkg;

    typedef enum logic [2:0] {
        cls_save_state,
        cls_startup,
        cls_plain,
        cls_alters_saved,
        cls_unsupported
    } cmd_class_type;

    typedef enum logic [1:0] {
        resp_ok,
        resp_refused,
        resp_unsupported,
        resp_restore_failed
    } resp_code_type;

    typedef enum logic {
        pwr_d0,
        pwr_d3
    } power_state_type;

endpackage

// File: shared/ordinal_attr_if.sv
// Lookup channel between the command gate and the ordinal attribute table.
`timescale 1ns/1ps
interface ordinal_attr_if;
    logic [7:0] ord;
    cmd_gate_pkg::cmd_class_type cls;

    modport lookup (output ord, input cls);
    modport table_side (input ord, output cls);
endinterface

// File: rtl/ordinal_attr_rom.sv
// Per-ordinal attribute table: support and saved-state alteration class.
`timescale 1ns/1ps
`include "cmd_gate_consts.svh"
module ordinal_attr_rom #(
    parameter bit O1_EN = 1'b0,
    parameter bit O2_EN = 1'b0,
    parameter bit O3_EN = 1'b0,
    parameter logic [6:0] OPT_MASK = 7'h00
) (
    ordinal_attr_if.table_side attr
);
    logic [7:0] opt_off;

    always_comb begin
        opt_off = attr.ord - `CG_ORD_OPT_LO;
        attr.cls = cmd_gate_pkg::cls_unsupported;
        if (attr.ord == `CG_ORD_SAVE_STATE) begin
            attr.cls = cmd_gate_pkg::cls_save_state;
        end else if (attr.ord == `CG_ORD_STARTUP) begin
            attr.cls = cmd_gate_pkg::cls_startup;
        end else if (attr.ord == `CG_ORD_PHYS_PRESENCE || attr.ord == `CG_ORD_ESTAB_RESET) begin
            attr.cls = cmd_gate_pkg::cls_plain; // [RL13]
        end else if (attr.ord >= `CG_ORD_ALTER_LO && attr.ord <= `CG_ORD_ALTER_HI) begin
            attr.cls = cmd_gate_pkg::cls_alters_saved; // [RL15]
        end else if (attr.ord >= `CG_ORD_MAND_LO && attr.ord <= `CG_ORD_MAND_HI) begin
            attr.cls = cmd_gate_pkg::cls_plain; // [RL11]
        end else if (attr.ord >= `CG_ORD_O1_LO && attr.ord <= `CG_ORD_O1_HI && O1_EN) begin
            attr.cls = cmd_gate_pkg::cls_plain; // [RL12]
        end else if (attr.ord >= `CG_ORD_O2_LO && attr.ord <= `CG_ORD_O2_HI && O2_EN) begin
            attr.cls = cmd_gate_pkg::cls_plain; // [RL12]
        end else if (attr.ord >= `CG_ORD_O3_LO && attr.ord <= `CG_ORD_O3_HI && O3_EN) begin
            attr.cls = cmd_gate_pkg::cls_plain; // [RL12]
        end else if (attr.ord >= `CG_ORD_OPT_LO && attr.ord <= `CG_ORD_OPT_HI) begin
            if (OPT_MASK[opt_off[2:0]]) begin
                attr.cls = cmd_gate_pkg::cls_plain;
            end
        end
        // Deleted ordinals and unmapped indices fall through as unsupported.
    end
endmodule

// File: rtl/command_set_power_state_gate.sv
// Command acceptance and device power state gate with saved-state tracking.
//
// Functional notes
// [RL1] After hardware init the device acts as D0, even if D1 or D2 exist.
// [RL2] Every command is refused while the power state is not D0.
// [RL3] D3 is left only by the hardware init signal, nothing else.
// [RL4] A save-state command keeps the device in D0 and accepting commands.
// [RL5] Strapping the power-down pin high disables the power-down protocol entirely.
// [RL6] The device is either fully working in D0 or dead in D3.
// [RL7] Save-state stores volatile contents; further commands still accepted afterwards.
// [RL8] A state-altering command after save-state voids the image; restore then fails.
// [RL9] Host must send save-state again to preserve the new state.
// [RL10] Startup selects restore or clear; device restores image or starts fresh.
// [RL11] Every mandatory ordinal is accepted; deleted ordinals are refused.
// [RL12] Optional ordinals sharing a flag are implemented all together or not at all.
// [RL13] Physical presence and establishment reset commands are always accepted; the gate refuses them in D3 and while init is held.
// [RL14] Device reset for power rules means assertion of the hardware init signal.
// [RL15] Per-ordinal attribute marks saved-state alteration; such commands clear the valid flag.
`timescale 1ns/1ps
`include "cmd_gate_consts.svh"
module command_set_power_state_gate #(
    parameter bit LPCPD_PROTOCOL_EN = 1'b1,
    parameter bit O1_EN = 1'b0,
    parameter bit O2_EN = 1'b0,
    parameter bit O3_EN = 1'b0,
    parameter logic [6:0] OPT_MASK = 7'h00
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic hw_init_signal,
    input wire logic lpcpd_n,
    input wire logic power_req_valid,
    input wire logic [1:0] power_req_state,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_ordinal,
    input wire logic startup_restore_option,
    output logic resp_valid_q,
    output cmd_gate_pkg::resp_code_type resp_code_q,
    output logic exec_strobe_q,
    output logic save_strobe_q,
    output logic restore_strobe_q,
    output logic clear_strobe_q,
    output logic in_d3_q,
    output logic saved_valid_q,
    output logic init_active_q
);

    ordinal_attr_if attr ();

    ordinal_attr_rom #(
        .O1_EN(O1_EN),
        .O2_EN(O2_EN),
        .O3_EN(O3_EN),
        .OPT_MASK(OPT_MASK)
    ) u_attr (
        .attr(attr)
    );

    assign attr.ord = cmd_ordinal;

    // Pin synchronisers. Stage 0 feeds only stage 1; the filter compares stages 1 and 2.

    logic [2:0] init_sync_q;
    logic [2:0] init_sync_d;
    logic [2:0] pd_sync_q;
    logic [2:0] pd_sync_d;
    logic init_filt_q;
    logic init_filt_d;
    logic pd_filt_q;
    logic pd_filt_d;

    always_comb begin
        init_sync_d = {init_sync_q[1:0], hw_init_signal};
        pd_sync_d = {pd_sync_q[1:0], lpcpd_n};
        init_filt_d = init_filt_q;
        pd_filt_d = pd_filt_q;
        if (init_sync_q[1] == init_sync_q[2]) begin
            init_filt_d = init_sync_q[2];
        end
        if (pd_sync_q[1] == pd_sync_q[2]) begin
            pd_filt_d = pd_sync_q[2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            init_sync_q <= `CG_RST_SYNC;
            pd_sync_q <= ~`CG_RST_SYNC;
            init_filt_q <= `CG_RST_INIT_FILT;
            pd_filt_q <= `CG_RST_PD_FILT;
        end else if (clk_en) begin
            init_sync_q <= init_sync_d;
            pd_sync_q <= pd_sync_d;
            init_filt_q <= init_filt_d;
            pd_filt_q <= pd_filt_d;
        end
    end

    // Power state. Only two states exist, so D1 and D2 requests have nowhere to go.

    cmd_gate_pkg::power_state_type pwr_q;
    cmd_gate_pkg::power_state_type pwr_d;
    logic pd_enter;
    logic req_enter;

    always_comb begin
        // A high strap keeps the pin from ever requesting power down.
        pd_enter = LPCPD_PROTOCOL_EN && !pd_filt_q; // [RL5]
        req_enter = power_req_valid && power_req_state == `CG_DSTATE_D3;
        pwr_d = pwr_q;
        unique case (pwr_q)
            cmd_gate_pkg::pwr_d0: begin
                if (init_filt_q) begin
                    pwr_d = cmd_gate_pkg::pwr_d0; // [RL1]
                end else if (pd_enter || req_enter) begin
                    pwr_d = cmd_gate_pkg::pwr_d3; // [RL6]
                end
            end
            cmd_gate_pkg::pwr_d3: begin
                // Pin release or a D0 request is ignored here on purpose.
                if (init_filt_q) begin
                    pwr_d = cmd_gate_pkg::pwr_d0; // [RL3] [RL14]
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pwr_q <= cmd_gate_pkg::pwr_d0;
        end else if (clk_en) begin
            pwr_q <= pwr_d;
        end
    end

    // Command gate and saved-image tracking.

    logic saved_valid_d;
    logic resp_valid_d;
    cmd_gate_pkg::resp_code_type resp_code_d;
    logic exec_strobe_d;
    logic save_strobe_d;
    logic restore_strobe_d;
    logic clear_strobe_d;
    logic gate_open;

    always_comb begin
        saved_valid_d = saved_valid_q;
        resp_valid_d = 1'b0;
        resp_code_d = cmd_gate_pkg::resp_ok;
        exec_strobe_d = 1'b0;
        save_strobe_d = 1'b0;
        restore_strobe_d = 1'b0;
        clear_strobe_d = 1'b0;
        // Init held high counts as reset in progress, so commands are refused until its release.
        gate_open = pwr_q == cmd_gate_pkg::pwr_d0 && !init_filt_q;
        if (cmd_valid) begin
            resp_valid_d = 1'b1;
            if (!gate_open) begin
                resp_code_d = cmd_gate_pkg::resp_refused; // [RL2]
            end else begin
                unique case (attr.cls)
                    cmd_gate_pkg::cls_save_state: begin
                        // Power may vanish any time after this, so the image is marked at once.
                        saved_valid_d = 1'b1; // [RL7] [RL15]
                        save_strobe_d = 1'b1; // [RL7]
                        exec_strobe_d = 1'b1; // [RL4]
                    end
                    cmd_gate_pkg::cls_startup: begin
                        if (startup_restore_option) begin
                            if (saved_valid_q) begin
                                restore_strobe_d = 1'b1; // [RL10]
                                exec_strobe_d = 1'b1;
                            end else begin
                                resp_code_d = cmd_gate_pkg::resp_restore_failed; // [RL8]
                            end
                        end else begin
                            clear_strobe_d = 1'b1; // [RL10]
                            exec_strobe_d = 1'b1;
                        end
                        // The image is consumed by either startup, so a second restore fails.
                        if (saved_valid_q && resp_code_d == cmd_gate_pkg::resp_ok) begin
                            saved_valid_d = 1'b0;
                        end
                    end
                    cmd_gate_pkg::cls_alters_saved: begin
                        saved_valid_d = 1'b0; // [RL8] [RL15]
                        exec_strobe_d = 1'b1;
                    end
                    cmd_gate_pkg::cls_plain: begin
                        exec_strobe_d = 1'b1; // [RL11] [RL13]
                    end
                    cmd_gate_pkg::cls_unsupported: begin
                        resp_code_d = cmd_gate_pkg::resp_unsupported; // [RL11] [RL12]
                    end
                    default: begin
                        resp_code_d = cmd_gate_pkg::resp_unsupported;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            saved_valid_q <= `CG_RST_SAVED_VALID;
            resp_valid_q <= 1'b0;
            resp_code_q <= cmd_gate_pkg::resp_ok;
            exec_strobe_q <= 1'b0;
            save_strobe_q <= 1'b0;
            restore_strobe_q <= 1'b0;
            clear_strobe_q <= 1'b0;
        end else if (clk_en) begin
            saved_valid_q <= saved_valid_d;
            resp_valid_q <= resp_valid_d;
            resp_code_q <= resp_code_d;
            exec_strobe_q <= exec_strobe_d;
            save_strobe_q <= save_strobe_d;
            restore_strobe_q <= restore_strobe_d;
            clear_strobe_q <= clear_strobe_d;
        end
    end

    // Status outputs, registered so they never glitch on the pins.

    logic in_d3_d;
    logic init_active_d;

    always_comb begin
        in_d3_d = pwr_d == cmd_gate_pkg::pwr_d3;
        init_active_d = init_filt_d;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            in_d3_q <= 1'b0;
            init_active_q <= 1'b0;
        end else if (clk_en) begin
            in_d3_q <= in_d3_d;
            init_active_q <= init_active_d;
        end
    end

endmodule

// File: verification/gate_checker_asserts.sv
// Port-level checks on the command gate.
`timescale 1ns/1ps
`include "cmd_gate_consts.svh"
module gate_checker (
    input logic core_clk,
    input logic reset,
    input logic cmd_valid,
    input logic [7:0] cmd_ordinal,
    input logic startup_restore_option,
    input logic resp_valid_q,
    input cmd_gate_pkg::resp_code_type resp_code_q,
    input logic exec_strobe_q,
    input logic save_strobe_q,
    input logic restore_strobe_q,
    input logic in_d3_q,
    input logic saved_valid_q,
    input logic init_active_q
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    wire ready = cmd_valid && !in_d3_q && !init_active_q;
    wire alter = cmd_ordinal >= `CG_ORD_ALTER_LO && cmd_ordinal <= `CG_ORD_ALTER_HI;
    wire del = cmd_ordinal >= `CG_ORD_DEL_LO && cmd_ordinal <= `CG_ORD_DEL_HI;
    property p_resp; cmd_valid |=> resp_valid_q; endproperty
    a_resp: assert property (p_resp) else $error("Missing response.");
    property p_refuse; cmd_valid && (in_d3_q || init_active_q) |=> resp_code_q == cmd_gate_pkg::resp_refused
        && !exec_strobe_q; endproperty
    a_refuse: assert property (p_refuse) else $error("Command taken outside D0.");
    property p_hold_d3; in_d3_q && !init_active_q |=> in_d3_q || init_active_q; endproperty
    a_hold_d3: assert property (p_hold_d3) else $error("Left D3 without init.");
    property p_init_d0; init_active_q ##1 init_active_q |-> !in_d3_q; endproperty
    a_init_d0: assert property (p_init_d0) else $error("Not D0 under init.");
    property p_save; ready && cmd_ordinal == `CG_ORD_SAVE_STATE |=> resp_code_q == cmd_gate_pkg::resp_ok
        && save_strobe_q && saved_valid_q && !in_d3_q; endproperty
    a_save: assert property (p_save) else $error("Save-state mishandled.");
    property p_alter; ready && alter |=> exec_strobe_q && !saved_valid_q; endproperty
    a_alter: assert property (p_alter) else $error("Image kept after alteration.");
    property p_rfail; ready && cmd_ordinal == `CG_ORD_STARTUP && startup_restore_option && !saved_valid_q
        |=> resp_code_q == cmd_gate_pkg::resp_restore_failed && !restore_strobe_q; endproperty
    a_rfail: assert property (p_rfail) else $error("Restore without image.");
    property p_conn; ready && (cmd_ordinal == `CG_ORD_PHYS_PRESENCE || cmd_ordinal == `CG_ORD_ESTAB_RESET)
        |=> resp_code_q == cmd_gate_pkg::resp_ok && exec_strobe_q; endproperty
    a_conn: assert property (p_conn) else $error("Connection command refused.");
    property p_del; ready && del |=> resp_code_q == cmd_gate_pkg::resp_unsupported && !exec_strobe_q; endproperty
    a_del: assert property (p_del) else $error("Deleted ordinal executed.");
    property p_vkeep; $changed(saved_valid_q) |-> resp_valid_q; endproperty
    a_vkeep: assert property (p_vkeep) else $error("Image flag moved without a command.");
    c_save: cover property (ready && cmd_ordinal == `CG_ORD_SAVE_STATE);
    c_restore: cover property (restore_strobe_q);
    c_d3: cover property ($rose(in_d3_q));
endmodule
bind command_set_power_state_gate gate_checker gate_checker_i (.core_clk(core_clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_ordinal(cmd_ordinal), .startup_restore_option(startup_restore_option),
    .resp_valid_q(resp_valid_q), .resp_code_q(resp_code_q), .exec_strobe_q(exec_strobe_q),
    .save_strobe_q(save_strobe_q), .restore_strobe_q(restore_strobe_q), .in_d3_q(in_d3_q),
    .saved_valid_q(saved_valid_q), .init_active_q(init_active_q));

// File: verification/host_model.sv
// Host software stand-in that issues commands to the gate.
`timescale 1ns/1ps
module host_model (
    input logic core_clk,
    output logic cmd_valid,
    output logic [7:0] cmd_ordinal,
    output logic startup_restore_option
);
    initial begin
        cmd_valid = 1'b0;
        cmd_ordinal = 8'h00;
        startup_restore_option = 1'b0;
    end
    // The caller sends save-state again after an invalidation and picks restore or clear.
    task automatic issue(input logic [7:0] o, input logic opt);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_ordinal = o;
        startup_restore_option = opt;
    endtask
    // Idle lines flip so that stale data can never pass for the last command.
    task automatic quiet();
        @(negedge core_clk);
        cmd_valid = 1'b0;
        cmd_ordinal = ~cmd_ordinal;
        startup_restore_option = ~startup_restore_option;
    endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the command gate.
`timescale 1ns/1ps
`include "cmd_gate_consts.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; $display("Error t=%0t got %0h exp %0h", $time, a, b); end end
module testbench;
    localparam logic [6:0] OPT_MASK = 7'h05;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic hw_init_signal = 1'b0;
    logic lpcpd_n = 1'b1;
    logic power_req_valid = 1'b0;
    logic clk_en = 1'b1;
    logic save_strobe_q, restore_strobe_q, clear_strobe_q;
    logic [2:0] es;
    logic [2:0] exp_strbs[$];
    logic [1:0] power_req_state = 2'h0;
    logic cmd_valid, startup_restore_option, resp_valid_q, exec_strobe_q, in_d3_q, saved_valid_q, init_active_q;
    logic [7:0] cmd_ordinal;
    logic [31:0] r;
    cmd_gate_pkg::resp_code_type resp_code_q, ec;
    cmd_gate_pkg::resp_code_type exp_codes[$];
    logic exp_valids[$];
    logic blk = 1'b0;
    logic sv = 1'b0;
    logic ev;
    int n_fail = 0;
    int num_checks = 0;
    int seed = 32'he5d76aac;
    always #2 core_clk = ~core_clk;
    host_model host_model_i (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_ordinal(cmd_ordinal),
        .startup_restore_option(startup_restore_option));
    command_set_power_state_gate #(.O1_EN(1'b1), .OPT_MASK(OPT_MASK)) command_set_power_state_gate_i (
        .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .hw_init_signal(hw_init_signal), .lpcpd_n(lpcpd_n),
        .power_req_valid(power_req_valid), .power_req_state(power_req_state), .cmd_valid(cmd_valid),
        .cmd_ordinal(cmd_ordinal), .startup_restore_option(startup_restore_option), .resp_valid_q(resp_valid_q),
        .resp_code_q(resp_code_q), .exec_strobe_q(exec_strobe_q), .save_strobe_q(save_strobe_q),
        .restore_strobe_q(restore_strobe_q), .clear_strobe_q(clear_strobe_q), .in_d3_q(in_d3_q),
        .saved_valid_q(saved_valid_q), .init_active_q(init_active_q));
    function automatic cmd_gate_pkg::resp_code_type exp_code(logic [7:0] o, logic opt);
        if (blk)
            return cmd_gate_pkg::resp_refused;
        if (o == `CG_ORD_STARTUP && opt && !sv)
            return cmd_gate_pkg::resp_restore_failed;
        if (o <= `CG_ORD_MAND_HI || (o >= `CG_ORD_O1_LO && o <= `CG_ORD_O1_HI))
            return cmd_gate_pkg::resp_ok;
        if (o >= `CG_ORD_OPT_LO && o <= `CG_ORD_OPT_HI && OPT_MASK[o - `CG_ORD_OPT_LO])
            return cmd_gate_pkg::resp_ok;
        return cmd_gate_pkg::resp_unsupported;
    endfunction
    task automatic cmd(logic [7:0] o, logic opt);
        cmd_gate_pkg::resp_code_type c;
        c = exp_code(o, opt);
        if (c == cmd_gate_pkg::resp_ok && (o == `CG_ORD_STARTUP || (o >= `CG_ORD_ALTER_LO && o <= `CG_ORD_ALTER_HI)))
            sv = 1'b0;
        if (c == cmd_gate_pkg::resp_ok && o == `CG_ORD_SAVE_STATE)
            sv = 1'b1;
        exp_codes.push_back(c);
        exp_valids.push_back(sv);
        exp_strbs.push_back({c == cmd_gate_pkg::resp_ok && o == `CG_ORD_SAVE_STATE,
            c == cmd_gate_pkg::resp_ok && o == `CG_ORD_STARTUP && opt,
            c == cmd_gate_pkg::resp_ok && o == `CG_ORD_STARTUP && !opt});
        host_model_i.issue(o, opt);
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(negedge core_clk) begin
        if (resp_valid_q === 1'b1 && exp_codes.size() > 0) begin
            ec = exp_codes.pop_front();
            ev = exp_valids.pop_front();
            es = exp_strbs.pop_front();
            `CHK(resp_code_q, ec)
            `CHK(saved_valid_q, ev)
            `CHK(exec_strobe_q, ec == cmd_gate_pkg::resp_ok)
            `CHK({save_strobe_q, restore_strobe_q, clear_strobe_q}, es)
        end
    end
    initial begin
        repeat (6) @(negedge core_clk);
        reset = 1'b0;
        `CHK(in_d3_q, 1'b0)
        for (int i = 0; i < 256; i++)
            cmd(i[7:0], i[0]);
        cmd(`CG_ORD_SAVE_STATE, 1'b0);
        cmd(8'h04, 1'b0);
        cmd(`CG_ORD_STARTUP, 1'b1);
        cmd(`CG_ORD_SAVE_STATE, 1'b0);
        cmd(8'h20, 1'b0);
        cmd(`CG_ORD_STARTUP, 1'b1);
        cmd(`CG_ORD_SAVE_STATE, 1'b0);
        cmd(`CG_ORD_STARTUP, 1'b0);
        repeat (300) begin
            r = $random(seed);
            power_req_valid = r[10];
            power_req_state = r[9:8] % 2'h3;
            cmd(r[7:0], r[11]);
        end
        host_model_i.quiet();
        power_req_valid = 1'b0;
        repeat (3) @(negedge core_clk);
        `CHK(in_d3_q, 1'b0)
        power_req_valid = 1'b1;
        power_req_state = 2'h3;
        @(negedge core_clk);
        power_req_valid = 1'b0;
        @(negedge core_clk);
        `CHK(in_d3_q, 1'b1)
        blk = 1'b1;
        power_req_valid = 1'b1;
        power_req_state = 2'h0;
        cmd(`CG_ORD_PHYS_PRESENCE, 1'b0);
        cmd(`CG_ORD_SAVE_STATE, 1'b0);
        host_model_i.quiet();
        power_req_valid = 1'b0;
        repeat (4) @(negedge core_clk);
        `CHK(in_d3_q, 1'b1)
        hw_init_signal = 1'b1;
        repeat (8) @(negedge core_clk);
        `CHK(init_active_q, 1'b1)
        `CHK(in_d3_q, 1'b0)
        cmd(`CG_ORD_ESTAB_RESET, 1'b0);
        host_model_i.quiet();
        hw_init_signal = 1'b0;
        repeat (8) @(negedge core_clk);
        blk = 1'b0;
        cmd(`CG_ORD_ESTAB_RESET, 1'b0);
        host_model_i.quiet();
        @(negedge core_clk);
        // A low clock enable must freeze the pin filters, so the power-down only lands once it returns.
        clk_en = 1'b0;
        lpcpd_n = 1'b0;
        repeat (8) @(negedge core_clk);
        `CHK(in_d3_q, 1'b0)
        clk_en = 1'b1;
        repeat (8) @(negedge core_clk);
        `CHK(in_d3_q, 1'b1)
        lpcpd_n = 1'b1;
        repeat (6) @(negedge core_clk);
        `CHK(in_d3_q, 1'b1)
        `CHK(exp_codes.size(), 0)
        close_out();
    end
    // Normal run is under 1000 cycles, so this margin only trips on a hang.
    initial begin
        #20000;
        n_fail++;
        close_out();
    end
endmodule
